/* verilog/lps_map.svh */
/*
 holds: register indices, field positions, reset values and counts
 of the rgbw led pwm sequencer.
 assumes: included by bare name; byte address is four times the index.
*/
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH
// -----------------------------------------------------------------
// register indices (byte address = index * 4)
// -----------------------------------------------------------------
`define LPS_IDX_EN 16'h3400
`define LPS_IDX_DIV 16'h3402
`define LPS_IDX_SLOPE 16'h340a
`define LPS_IDX_MAXD 16'h340c
`define LPS_IDX_WHITE 16'h340e
`define LPS_IDX_RONOFF 16'h3410
`define LPS_IDX_GONOFF 16'h3412
`define LPS_IDX_BONOFF 16'h3414
`define LPS_IDX_STATUS 16'h3416
// -----------------------------------------------------------------
// fields, reset value and counts
// -----------------------------------------------------------------
`define LPS_EN_WHITE 8
`define LPS_EN_RED 9
`define LPS_EN_GATE 12
`define LPS_REG_RST 16'h0000
`define LPS_PER_LAST 7'h7f
`define LPS_PH_LAST 4'hf
`define LPS_WPRE_LOW 2'h3 // white prescale ends after four source edges per period step
`define LPS_RESP_OKAY 2'h0
`define LPS_RESP_SLVERR 2'h2
`endif

/* verilog/lps_pkg.sv */
/*
 holds: types of the rgbw led pwm sequencer.
 assumes: nothing; used by scoped names only.
*/
`default_nettype none
package lps_pkg;
	// colour channel ramp states
	typedef enum logic [1:0] {LPS_IDLE, LPS_UP, LPS_HOLD, LPS_DOWN} lps_ramp_t;

	typedef struct packed {
		lps_ramp_t st;
		logic [3:0] duty;
		logic [7:0] sc;
	} lps_chan_t;

	typedef struct packed {
		logic [15:0] en;
		logic [15:0] div;
		logic [15:0] slope;
		logic [15:0] maxd;
		logic [15:0] white;
		logic [2:0][15:0] onoff;
		logic src_q;
		logic [3:0] divc;
		logic [3:0] ph;
		logic [6:0] per;
		lps_chan_t [2:0] ch;
		logic [13:0] wpre;
		logic [5:0] wph;
		logic awr;
		logic wr;
		logic arr;
		logic bv;
		logic rv;
		logic [15:0] awa;
		logic [15:0] wd;
		logic [1:0] ws;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [15:0] rd;
		logic [3:0] led;
	} lps_state_t;
endpackage
`default_nettype wire

/* verilog/lps_rgbw_pwm.sv */
/*
 holds: rgbw led pwm sequencer with an axi4-lite register slave.
 assumes: led_source_clock and the gate pin are synchronous to aclk;
 led_source_clock is much slower than aclk.
*/
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "lps_map.svh"

module lps_rgbw_pwm #(
	parameter int ADDR_W = 16
) (
	input wire logic aclk, // system clock, 20 mhz
	input wire logic aresetn, // sync reset, low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic led_source_clock, // slow pwm source clock
	input wire logic external_output_gate_in, // output gate pin
	output logic led_red, // red drive
	output logic led_green, // green drive
	output logic led_blue, // blue drive
	output logic led_white // white drive
);
	if (ADDR_W < 16) begin : g_chk
		$error("ADDR_W must be at least 16");
	end

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [15:0] idx(input logic [15:0] a);
		return {2'h0, a[15:2]};
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d, input logic [1:0] s);
		return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction

	// one ramp step per pulse clock for a colour channel
	function automatic lps_pkg::lps_chan_t ramp(input lps_pkg::lps_chan_t c, input logic on_hit,
		input logic off_hit, input logic [7:0] sl, input logic [3:0] mx);
		lps_pkg::lps_chan_t r;
		logic step;
		logic flat;
		r = c;
		flat = (sl == 8'h00);
		step = flat || (c.sc >= sl - 8'h01);
		r.sc = step ? 8'h00 : c.sc + 8'h01;
		unique case (c.st)
			lps_pkg::LPS_IDLE: begin
				r.sc = 8'h00;
				if (on_hit) begin
					r.st = flat ? lps_pkg::LPS_HOLD : lps_pkg::LPS_UP;
					r.duty = flat ? mx : 4'h0;
				end
			end
			lps_pkg::LPS_UP: begin
				if (off_hit) begin
					r.st = flat ? lps_pkg::LPS_IDLE : lps_pkg::LPS_DOWN;
					r.duty = flat ? 4'h0 : c.duty;
					r.sc = 8'h00;
				end else if (c.duty >= mx) begin
					r.st = lps_pkg::LPS_HOLD;
					r.duty = mx;
				end else if (step) begin
					r.duty = c.duty + 4'h1;
				end
			end
			lps_pkg::LPS_HOLD: begin
				if (off_hit) begin
					r.st = flat ? lps_pkg::LPS_IDLE : lps_pkg::LPS_DOWN;
					r.duty = flat ? 4'h0 : c.duty;
					r.sc = 8'h00;
				end else begin
					r.duty = mx;
				end
			end
			lps_pkg::LPS_DOWN: begin
				if (on_hit) begin
					r.st = flat ? lps_pkg::LPS_HOLD : lps_pkg::LPS_UP;
					r.duty = flat ? mx : c.duty;
					r.sc = 8'h00;
				end else if (c.duty == 4'h0) begin
					r.st = lps_pkg::LPS_IDLE;
				end else if (step) begin
					r.duty = c.duty - 4'h1;
				end
			end
		endcase
		return r;
	endfunction

	// read mux: response code over data
	function automatic logic [17:0] rdmux(input logic [15:0] i, input lps_pkg::lps_state_t s);
		logic [17:0] v;
		v = {`LPS_RESP_OKAY, 16'h0000};
		case (i)
			`LPS_IDX_EN: v[15:0] = s.en;
			`LPS_IDX_DIV: v[15:0] = s.div;
			`LPS_IDX_SLOPE: v[15:0] = s.slope;
			`LPS_IDX_MAXD: v[15:0] = s.maxd;
			`LPS_IDX_WHITE: v[15:0] = s.white;
			`LPS_IDX_RONOFF: v[15:0] = s.onoff[0];
			`LPS_IDX_GONOFF: v[15:0] = s.onoff[1];
			`LPS_IDX_BONOFF: v[15:0] = s.onoff[2];
			`LPS_IDX_STATUS: v[15:0] = {2'h0, s.ch[2].st, s.ch[1].st, s.ch[0].st, 1'b0, s.per};
			default: v[17:16] = `LPS_RESP_SLVERR;
		endcase
		return v;
	endfunction

	// -----------------------------------------------------------------
	// state and timing strobes
	// -----------------------------------------------------------------
	lps_pkg::lps_state_t q_ff;
	lps_pkg::lps_state_t nxt_q;
	logic run;
	logic se;
	logic pwt;
	logic pt;
	logic rgb_on;
	logic gate_ok;

	// source edge only while some channel is on; pwm and pulse ticks follow
	assign run = |q_ff.en[11:8];
	assign se = led_source_clock & ~q_ff.src_q & run;
	assign pwt = se && (q_ff.divc == q_ff.div[3:0]);
	assign pt = pwt && (q_ff.ph == `LPS_PH_LAST);
	assign rgb_on = |q_ff.en[11:9];
	assign gate_ok = !q_ff.en[`LPS_EN_GATE] || external_output_gate_in;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		nxt_q = q_ff;
		nxt_q.src_q = led_source_clock;
		// divider, pwm phase and shared 128 count period
		if (se) begin
			nxt_q.divc = pwt ? 4'h0 : q_ff.divc + 4'h1;
		end
		if (pwt) begin
			nxt_q.ph = q_ff.ph + 4'h1;
		end
		if (pt) begin
			nxt_q.per = (q_ff.per == `LPS_PER_LAST) ? 7'h00 : q_ff.per + 7'h01;
		end
		// per colour ramp, placed by its own on and off times
		for (int i = 0; i < 3; i++) begin
			if (pt) begin
				nxt_q.ch[i] = ramp(q_ff.ch[i], q_ff.per == q_ff.onoff[i][6:0], q_ff.per == q_ff.onoff[i][14:8],
					q_ff.slope[7:0], q_ff.maxd[3:0]);
			end
		end
		if (!rgb_on) begin
			nxt_q.divc = 4'h0;
			nxt_q.ph = 4'h0;
			nxt_q.per = 7'h00;
			nxt_q.ch = '0;
		end
		// white: prescale 4*(p+1) source edges per duty step, no ramp; 64 steps give 64 hz down to 1 hz
		if (!q_ff.en[`LPS_EN_WHITE]) begin
			nxt_q.wpre = 14'h0000;
			nxt_q.wph = 6'h00;
		end else if (se) begin
			if (q_ff.wpre == {6'h00, q_ff.white[13:8], `LPS_WPRE_LOW}) begin
				nxt_q.wpre = 14'h0000;
				nxt_q.wph = q_ff.wph + 6'h01;
			end else begin
				nxt_q.wpre = q_ff.wpre + 14'h0001;
			end
		end
		// output stage, gated by the external pin
		for (int i = 0; i < 3; i++) begin
			nxt_q.led[i] = q_ff.en[`LPS_EN_RED + i] && (q_ff.ch[i].st != lps_pkg::LPS_IDLE)
				&& (q_ff.ph < q_ff.ch[i].duty) && gate_ok;
		end
		nxt_q.led[3] = q_ff.en[`LPS_EN_WHITE] && (q_ff.wph < q_ff.white[5:0]) && gate_ok;
		// axi write: address and data in either order, then response
		if (s_axi_awvalid && q_ff.awr) begin
			nxt_q.awr = 1'b0;
			nxt_q.awa = s_axi_awaddr[15:0];
		end
		if (s_axi_wvalid && q_ff.wr) begin
			nxt_q.wr = 1'b0;
			nxt_q.wd = s_axi_wdata[15:0];
			nxt_q.ws = s_axi_wstrb[1:0];
		end
		if (!q_ff.awr && !q_ff.wr && !q_ff.bv) begin
			nxt_q.bv = 1'b1;
			nxt_q.bresp = `LPS_RESP_OKAY;
			case (idx(q_ff.awa))
				`LPS_IDX_EN: nxt_q.en = merge(q_ff.en, q_ff.wd, q_ff.ws);
				`LPS_IDX_DIV: nxt_q.div = merge(q_ff.div, q_ff.wd, q_ff.ws);
				`LPS_IDX_SLOPE: nxt_q.slope = merge(q_ff.slope, q_ff.wd, q_ff.ws);
				`LPS_IDX_MAXD: nxt_q.maxd = merge(q_ff.maxd, q_ff.wd, q_ff.ws);
				`LPS_IDX_WHITE: nxt_q.white = merge(q_ff.white, q_ff.wd, q_ff.ws);
				`LPS_IDX_RONOFF: nxt_q.onoff[0] = merge(q_ff.onoff[0], q_ff.wd, q_ff.ws);
				`LPS_IDX_GONOFF: nxt_q.onoff[1] = merge(q_ff.onoff[1], q_ff.wd, q_ff.ws);
				`LPS_IDX_BONOFF: nxt_q.onoff[2] = merge(q_ff.onoff[2], q_ff.wd, q_ff.ws);
				`LPS_IDX_STATUS: nxt_q.bresp = `LPS_RESP_OKAY; // read only, write ignored
				default: nxt_q.bresp = `LPS_RESP_SLVERR;
			endcase
		end
		if (q_ff.bv && s_axi_bready) begin
			nxt_q.bv = 1'b0;
			nxt_q.awr = 1'b1;
			nxt_q.wr = 1'b1;
		end
		// axi read: answered one cycle after the address is taken
		if (s_axi_arvalid && q_ff.arr) begin
			nxt_q.arr = 1'b0;
			nxt_q.rv = 1'b1;
			{nxt_q.rresp, nxt_q.rd} = rdmux(idx(s_axi_araddr[15:0]), q_ff);
		end
		if (q_ff.rv && s_axi_rready) begin
			nxt_q.rv = 1'b0;
			nxt_q.arr = 1'b1;
		end
	end

	// register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_ff <= '0;
			q_ff.en <= `LPS_REG_RST;
			q_ff.awr <= 1'b1;
			q_ff.wr <= 1'b1;
			q_ff.arr <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign s_axi_awready = q_ff.awr;
	assign s_axi_wready = q_ff.wr;
	assign s_axi_bvalid = q_ff.bv;
	assign s_axi_bresp = q_ff.bresp;
	assign s_axi_arready = q_ff.arr;
	assign s_axi_rvalid = q_ff.rv;
	assign s_axi_rresp = q_ff.rresp;
	assign s_axi_rdata = {16'h0000, q_ff.rd};
	assign led_red = q_ff.led[0];
	assign led_green = q_ff.led[1];
	assign led_blue = q_ff.led[2];
	assign led_white = q_ff.led[3];

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	div_tick_a: assert property (rgb_on && se |=> q_ff.divc == ($past(pwt) ? 4'h0 : $past(q_ff.divc) + 4'h1))
		else $error("pwm tick off the divider count");
	pwm_wrap_a: assert property (rgb_on && pwt && q_ff.ph == 4'hf |=> q_ff.ph == 4'h0)
		else $error("pwm cycle not sixteen clocks");
	period_wrap_a: assert property (rgb_on && pt && q_ff.per == 7'h7f |=> q_ff.per == 7'h00)
		else $error("period not 128 pulse clocks");
	ramp_start_a: assert property (rgb_on && pt && q_ff.slope[7:0] != 8'h00 && q_ff.ch[0].st == lps_pkg::LPS_IDLE
		&& q_ff.per == q_ff.onoff[0][6:0] |=> q_ff.ch[0].st == lps_pkg::LPS_UP && q_ff.ch[0].duty == 4'h0)
		else $error("ramp did not start from zero");
	ramp_cut_a: assert property (rgb_on && pt && q_ff.slope[7:0] != 8'h00 && q_ff.ch[0].st == lps_pkg::LPS_UP
		&& q_ff.per == q_ff.onoff[0][14:8] |=> q_ff.ch[0].st == lps_pkg::LPS_DOWN && $stable(q_ff.ch[0].duty))
		else $error("off time did not cut the ramp");
	step_on_a: assert property (rgb_on && pt && q_ff.slope[7:0] == 8'h00 && q_ff.ch[1].st == lps_pkg::LPS_IDLE
		&& q_ff.per == q_ff.onoff[1][6:0] |=> q_ff.ch[1].duty == $past(q_ff.maxd[3:0]))
		else $error("zero slope did not jump to full duty");
	hold_max_a: assert property (rgb_on && q_ff.ch[2].st == lps_pkg::LPS_HOLD && !pt
		|=> q_ff.ch[2].st == lps_pkg::LPS_HOLD && $stable(q_ff.ch[2].duty))
		else $error("hold left before off time");
	halt_a: assert property (!run ##1 !run |=> $stable(q_ff.ph) && $stable(q_ff.divc) && $stable(q_ff.wpre) && $stable(q_ff.wph))
		else $error("pwm logic ran with all enables clear");
	rgb_reset_a: assert property (!rgb_on |=> q_ff.per == 7'h00 && q_ff.ch == '0 ##1 !led_red)
		else $error("colour logic not reset");
	gate_a: assert property (q_ff.en[12] && !external_output_gate_in |=> !led_red && !led_green && !led_blue && !led_white)
		else $error("gate pin did not block outputs");
	white_off_a: assert property (!q_ff.en[8] |=> !led_white && q_ff.wph == 6'h00)
		else $error("white ran while disabled");

	ramp_hold_c: cover property (q_ff.ch[0].st == lps_pkg::LPS_UP ##1 q_ff.ch[0].st == lps_pkg::LPS_HOLD);
	ramp_cut_c: cover property (q_ff.ch[0].st == lps_pkg::LPS_UP ##1 q_ff.ch[0].st == lps_pkg::LPS_DOWN);
	white_on_c: cover property (led_white);
endmodule // lps_rgbw_pwm
`default_nettype wire

/* test/lps_led_partner.sv */
/*
 holds: far side model: led source clock, gate pin and on-time counters of the four drives.
 assumes: one aclk domain; the bench pulses clr to open a counting window.
*/
`timescale 1ns/1ns
`default_nettype none
module lps_led_partner (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, low
	input wire logic gate_level, // commanded gate pin level
	input wire logic clr, // clears the counters
	input wire logic led_red, // red drive seen
	input wire logic led_green, // green drive seen
	input wire logic led_blue, // blue drive seen
	input wire logic led_white, // white drive seen
	output logic led_source_clock, // source clock, four aclk period
	output logic external_output_gate_in, // gate pin
	output logic [31:0] cnt_red, // red high cycles
	output logic [31:0] cnt_green, // green high cycles
	output logic [31:0] cnt_blue, // blue high cycles
	output logic [31:0] cnt_white // white high cycles
);
	logic [1:0] tick_ff;
	// ----------------------------------------
	// source clock and gate pin
	// ----------------------------------------
	// free running source clock, toggles every two aclk to keep runs short
	always_ff @(posedge aclk) begin
		if (!aresetn) tick_ff <= 2'h0;
		else tick_ff <= tick_ff + 2'h1;
	end
	assign led_source_clock = tick_ff[1];
	assign external_output_gate_in = gate_level;
	// ----------------------------------------
	// on-time counters
	// ----------------------------------------
	// counts aclk cycles with each drive high since the last clear
	always_ff @(posedge aclk) begin
		if (clr) begin
			cnt_red <= 32'h0;
			cnt_green <= 32'h0;
			cnt_blue <= 32'h0;
			cnt_white <= 32'h0;
		end else begin
			cnt_red <= cnt_red + {31'h0, led_red};
			cnt_green <= cnt_green + {31'h0, led_green};
			cnt_blue <= cnt_blue + {31'h0, led_blue};
			cnt_white <= cnt_white + {31'h0, led_white};
		end
	end
endmodule // lps_led_partner
`default_nettype wire

/* test/rgbw_led_pwm_sequencer_tb.sv */
/*
 holds: self-checking bench of the rgbw led pwm sequencer over axi4-lite.
 assumes: lps_led_partner makes a four aclk source clock and counts drive cycles.
*/
`timescale 1ns/1ns
`default_nettype none
`include "lps_map.svh"
module rgbw_led_pwm_sequencer_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [15:0] awa = 16'h0;
	logic [15:0] ara = 16'h0;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0, gate = 1'b1, clr = 1'b0;
	logic awr, wr_rdy, bv, arr, rv, src, gin, l_r, l_g, l_b, l_w;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, cnt_red, cnt_green, cnt_blue, cnt_white;
	logic [15:0] tab [9] = '{`LPS_IDX_EN, `LPS_IDX_DIV, `LPS_IDX_SLOPE, `LPS_IDX_MAXD, `LPS_IDX_WHITE,
		`LPS_IDX_RONOFF, `LPS_IDX_GONOFF, `LPS_IDX_BONOFF, `LPS_IDX_STATUS};
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	lps_rgbw_pwm #(.ADDR_W(16)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd),
		.led_source_clock(src), .external_output_gate_in(gin), .led_red(l_r), .led_green(l_g),
		.led_blue(l_b), .led_white(l_w));
	lps_led_partner u_led (.aclk(aclk), .aresetn(aresetn), .gate_level(gate), .clr(clr), .led_red(l_r),
		.led_green(l_g), .led_blue(l_b), .led_white(l_w), .led_source_clock(src), .external_output_gate_in(gin),
		.cnt_red(cnt_red), .cnt_green(cnt_green), .cnt_blue(cnt_blue), .cnt_white(cnt_white));

	// ----------------------------------------
	// clock, timeout and verdict
	// ----------------------------------------
	always #25 aclk = ~aclk;
	task automatic wrap_up();
		if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// cuts a hang short
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 100000) begin
			fail_count++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// bus cycles and comparisons
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	// one write, address and data offered together, ends when the response is taken
	task automatic wr(input logic [15:0] idx, input logic [15:0] val, input logic [1:0] er);
		logic a, w, b;
		a = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		awa <= {idx[13:0], 2'b00};
		wd <= {16'h0, val};
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		do begin
			@(posedge aclk);
			b = bv;
			if (awr && !a) awv <= 1'b0;
			if (awr) a = 1'b1;
			if (wr_rdy && !w) wv <= 1'b0;
			if (wr_rdy) w = 1'b1;
		end while (!b);
		brd <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
		logic g;
		@(posedge aclk);
		ara <= {idx[13:0], 2'b00};
		arv <= 1'b1;
		rrd <= 1'b1;
		do begin
			@(posedge aclk);
			g = rv;
			if (arr) arv <= 1'b0;
		end while (!g);
		d = rdata;
		r = rresp;
		rrd <= 1'b0;
	endtask
	task automatic rdchk(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(idx, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, er});
	endtask
	// polls the status word until the period count shows t
	task automatic wait_per(input logic [6:0] t, output logic [31:0] d);
		logic [1:0] r;
		do begin
			rd(`LPS_IDX_STATUS, d, r);
		end while (d[6:0] !== t);
	endtask
	// counts drive cycles over n clocks, then compares the four counts
	task automatic meas(input int n, input logic [31:0] er, input logic [31:0] eg, input logic [31:0] eb);
		@(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		repeat (n) @(posedge aclk);
		#1;
		chk(cnt_red, er);
		chk(cnt_green, eg);
		chk(cnt_blue, eb);
		chk(cnt_white, 32'h0);
	endtask
	// colours off while reprogramming, then divider, slope, max duty and on/off times
	task automatic cfg(input logic [15:0] dv, sl, mx, r, g, b);
		wr(`LPS_IDX_EN, 16'h0000, `LPS_RESP_OKAY);
		wr(`LPS_IDX_DIV, dv, `LPS_RESP_OKAY);
		wr(`LPS_IDX_SLOPE, sl, `LPS_RESP_OKAY);
		wr(`LPS_IDX_MAXD, mx, `LPS_RESP_OKAY);
		wr(`LPS_IDX_RONOFF, r, `LPS_RESP_OKAY);
		wr(`LPS_IDX_GONOFF, g, `LPS_RESP_OKAY);
		wr(`LPS_IDX_BONOFF, b, `LPS_RESP_OKAY);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (200) @(posedge aclk);
		for (int i = 0; i < 9; i++) rdchk(tab[i], 32'h0, `LPS_RESP_OKAY);
		rdchk(16'h3404, 32'h0, `LPS_RESP_SLVERR);
		wr(16'h3404, 16'hffff, `LPS_RESP_SLVERR);
		wr(`LPS_IDX_STATUS, 16'h00ff, `LPS_RESP_OKAY);
		for (int i = 1; i < 8; i++) begin
			wr(tab[i], 16'ha5c3 ^ 16'(i), `LPS_RESP_OKAY);
			rdchk(tab[i], {16'h0, 16'ha5c3 ^ 16'(i)}, `LPS_RESP_OKAY);
		end
		// zero slope colours, gate enabled and open, then closed
		cfg(16'h0000, 16'h0000, 16'h0008, 16'h0500, 16'h0d0a, 16'h1614);
		wr(`LPS_IDX_EN, 16'h1e00, `LPS_RESP_OKAY);
		repeat (8192) @(posedge aclk);
		meas(8192, 32'd160, 32'd96, 32'd64);
		@(posedge aclk);
		gate <= 1'b0;
		meas(1024, 32'h0, 32'h0, 32'h0);
		@(posedge aclk);
		gate <= 1'b1;
		// divide by two doubles every count
		wr(`LPS_IDX_EN, 16'h0000, `LPS_RESP_OKAY);
		rdchk(`LPS_IDX_STATUS, 32'h0, `LPS_RESP_OKAY);
		wr(`LPS_IDX_DIV, 16'h0001, `LPS_RESP_OKAY);
		wr(`LPS_IDX_EN, 16'h0e00, `LPS_RESP_OKAY);
		repeat (16384) @(posedge aclk);
		meas(16384, 32'd320, 32'd192, 32'd128);
		// sloped ramps: red holds, green cut short, blue starts late
		cfg(16'h0000, 16'h0004, 16'h0004, 16'h3c00, 16'h0800, 16'h6414);
		wr(`LPS_IDX_EN, 16'h0e00, `LPS_RESP_OKAY);
		wait_per(7'h7f, d);
		wait_per(7'h0a, d);
		chk(d, 32'h0000_0d0a);
		wait_per(7'h1e, d);
		chk(d, 32'h0000_121e);
		// white alone: zero duty, near full duty, disabled
		wr(`LPS_IDX_EN, 16'h0000, `LPS_RESP_OKAY);
		wr(`LPS_IDX_WHITE, 16'h0000, `LPS_RESP_OKAY);
		wr(`LPS_IDX_EN, 16'h0100, `LPS_RESP_OKAY);
		meas(2048, 32'h0, 32'h0, 32'h0);
		wr(`LPS_IDX_WHITE, 16'h003f, `LPS_RESP_OKAY);
		repeat (16) @(posedge aclk);
		@(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		repeat (2048) @(posedge aclk);
		#1;
		chk(cnt_white, 32'd2016);
		wr(`LPS_IDX_EN, 16'h0000, `LPS_RESP_OKAY);
		meas(256, 32'h0, 32'h0, 32'h0);
		wrap_up();
	end
endmodule // rgbw_led_pwm_sequencer_tb
`default_nettype wire
